// ---- rtl/interrupt_source_vector_map.sv ----
// Interrupt source classifier and vector resolver with an AXI4-Lite register slave.
// Assumes the CPU presents one trap request per instruction and takes one vector per pulse.
// How it works
// - Maskable sources need the global mask flag set; software sets their levels.
// - Non-maskable sources ignore the global mask flag and have no level.
// - Illegal opcode instruction traps through fixed vector 0FFDCh to 0FFDFh.
// - Overflow trap fires only with wrap flag 1, vector 0FFE0h to 0FFE3h.
// - Breakpoint uses 0FFE4h, or relocatable entry 0 when byte 0FFE6h is FFh.
// - Software trap numbers 0 to 63 dispatch through the relocatable entry.
// - Trap numbers 0 to 31 push stack select flag, then clear it.
// - Returning from such a routine restores the stack select flag.
// - Trap numbers 32 to 63 leave the stack select flag unchanged.
// - Instruction traps are all non-maskable, never blocked by the mask flag.
// - Watchdog, oscillation stop and non-maskable monitors share vector 0FFF0h.
// - Voltage monitor 1 is non-maskable when choice 0, else maskable number 50.
// - Voltage monitor 2 is non-maskable when choice 0, else maskable number 51.
// - Enabled address match raises non-maskable interrupt before fetch, vector 0FFE8h.
// - Each vector is four bytes; the CPU branches to the stored address.
// - Fixed table spans 0FFDCh to 0FFFFh; reset 0FFFCh, 0FFF8h reserved.
// - Relocatable table is 256 bytes at base; entry n at base plus 4n.
// - Peripheral sources are maskable with their documented numbers 1 to 18.
// - Pins, timers, bus collision and sensor unit use numbers 21 to 42.
// - Each peripheral request maps to one relocatable entry and level setting.
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module interrupt_source_vector_map
    import isvm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire trap_req_t trap_req,
    input wire logic wrap_flag,
    input wire logic [7:0] brk_mark_byte,
    input wire logic [ADDR_W-1:0] fetch_addr,
    input wire logic fetch_valid,
    input wire logic iret,
    input wire logic iret_restore,
    input wire logic iret_u,
    input wire logic [15:0] periph_req,
    input wire logic wdt_evt,
    input wire logic osc_stop_evt,
    input wire logic vmon1_evt,
    input wire logic vmon2_evt,
    output vec_t vec_o,
    output logic u_flag
);
    typedef struct packed {
        logic aw_rdy;
        logic aw_full;
        logic [7:0] aw_addr;
        logic w_rdy;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic b_valid;
        logic [1:0] b_resp;
        logic ar_rdy;
        logic r_valid;
        logic [31:0] r_data;
        logic [1:0] r_resp;
        logic [31:0] ctrl;
        logic [ADDR_W-1:0] vbase;
        logic [ADDR_W-1:0] m0;
        logic [ADDR_W-1:0] m1;
        logic [95:0] lvl;
        logic [NSLOT-1:0] pend;
        logic [3:0] spec;
        logic u;
        vec_t vec;
        logic [ADDR_W-1:0] last_addr;
        logic [NUM_W-1:0] last_num;
        logic last_nmi;
    } state_t;

    state_t s, n;

    // entry n at base plus four n
    function automatic logic [ADDR_W-1:0] reloc(input logic [ADDR_W-1:0] base, input logic [NUM_W-1:0] num);
        return base + {12'h000, num, 2'h0};
    endfunction

    function automatic logic [2:0] lvl_of(input logic [95:0] l, input int k);
        return l[k*LVL_STRIDE +: 3];
    endfunction

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Returns hit flag above the word
    function automatic logic [32:0] rd_reg(input state_t st, input logic [7:0] a);
        case (a)
            REG_CTRL: return {1'b1, st.ctrl};
            REG_STAT: return {1'b1, 4'h0, st.u, st.last_nmi, st.last_num, st.last_addr};
            REG_VBASE: return {1'b1, 12'h000, st.vbase};
            REG_MATCH0: return {1'b1, 12'h000, st.m0};
            REG_MATCH1: return {1'b1, 12'h000, st.m1};
            REG_LVL0: return {1'b1, st.lvl[31:0]};
            REG_LVL1: return {1'b1, st.lvl[63:32]};
            REG_LVL2: return {1'b1, st.lvl[95:64]};
            REG_PEND: return {1'b1, 14'h0000, st.pend};
            default: return {1'b0, 32'h00000000};
        endcase
    endfunction

    logic aw_take, w_take, ar_take, wr_go, m_hit;
    logic [32:0] wold, rword;
    logic [31:0] wv;
    logic [NSLOT-1:0] pend_clr;
    logic [3:0] spec_new;
    logic [2:0] best_lv, ipl;
    int best;

    always_comb begin
        n = s;
        aw_take = 1'b0;
        w_take = 1'b0;
        ar_take = 1'b0;
        wr_go = 1'b0;
        m_hit = 1'b0;
        wold = '0;
        rword = '0;
        wv = '0;
        pend_clr = '0;
        spec_new = '0;
        best_lv = '0;
        best = 0;
        ipl = s.ctrl[CTRL_IPL +: 3];
        n.vec = '0;
        // Write path: address and data may arrive in either order
        aw_take = awvalid & s.aw_rdy;
        w_take = wvalid & s.w_rdy;
        if (aw_take) begin
            n.aw_full = 1'b1;
            n.aw_addr = awaddr;
        end
        if (w_take) begin
            n.w_full = 1'b1;
            n.w_data = wdata;
            n.w_strb = wstrb;
        end
        if (s.b_valid & bready) begin
            n.b_valid = 1'b0;
        end
        wr_go = n.aw_full & n.w_full & ~n.b_valid;
        if (wr_go) begin
            wold = rd_reg(s, n.aw_addr);
            wv = wmerge(wold[31:0], n.w_data, n.w_strb);
            n.aw_full = 1'b0;
            n.w_full = 1'b0;
            n.b_valid = 1'b1;
            n.b_resp = wold[32] ? RESP_OKAY : RESP_SLVERR;
            case (n.aw_addr)
                // software sets mask flag and levels
                REG_CTRL: n.ctrl = wv & CTRL_MASK;
                REG_VBASE: n.vbase = wv[ADDR_W-1:0];
                REG_MATCH0: n.m0 = wv[ADDR_W-1:0];
                REG_MATCH1: n.m1 = wv[ADDR_W-1:0];
                REG_LVL0: n.lvl[31:0] = wv;
                REG_LVL1: n.lvl[63:32] = wv;
                REG_LVL2: n.lvl[95:64] = wv;
                // Request bits only take a zero from software
                REG_PEND: pend_clr = ~wv[NSLOT-1:0];
                default: n.ctrl = s.ctrl;
            endcase
        end
        // Read path: one cycle from address to data
        ar_take = arvalid & s.ar_rdy;
        if (s.r_valid & rready) begin
            n.r_valid = 1'b0;
        end
        if (ar_take) begin
            rword = rd_reg(s, araddr);
            n.r_valid = 1'b1;
            n.r_data = rword[31:0];
            n.r_resp = rword[32] ? RESP_OKAY : RESP_SLVERR;
        end
        m_hit = fetch_valid & ((s.ctrl[CTRL_ME0] & (fetch_addr == s.m0)) |
                               (s.ctrl[CTRL_ME1] & (fetch_addr == s.m1)));
        // fixed vectors stay inside the table
        // Dispatch: instruction traps, match, special, then maskable
        if (trap_req.valid) begin
            // instruction traps bypass the mask flag
            n.vec.nmi = 1'b1;
            case (trap_req.kind)
                TRAP_UND: begin
                    n.vec.valid = 1'b1;
                    n.vec.fixed = 1'b1;
                    n.vec.addr = VEC_UND;
                end
                TRAP_OVF: begin
                    n.vec.valid = wrap_flag;
                    n.vec.fixed = 1'b1;
                    n.vec.addr = VEC_OVF;
                end
                TRAP_BRK: begin
                    // relocated when the mark byte is erased
                    n.vec.valid = 1'b1;
                    n.vec.fixed = (brk_mark_byte != BRK_RELOC_MARK);
                    n.vec.num = NUM_BRK;
                    n.vec.addr = n.vec.fixed ? VEC_BRK : reloc(s.vbase, NUM_BRK);
                end
                TRAP_SWI: begin
                    // same entry as a matching peripheral
                    n.vec.valid = 1'b1;
                    n.vec.num = trap_req.num;
                    n.vec.addr = reloc(s.vbase, trap_req.num);
                    if (trap_req.num < SWI_KEEP_U) begin
                        n.vec.push_u = 1'b1;
                        n.vec.u_saved = s.u;
                        n.u = 1'b0;
                    end
                    // upper numbers keep the current stack
                end
                default: n.vec.nmi = 1'b0;
            endcase
        // match and special skip mask flag and level
        end else if (m_hit) begin
            n.vec.valid = 1'b1;
            n.vec.nmi = 1'b1;
            n.vec.fixed = 1'b1;
            n.vec.addr = VEC_MATCH;
        end else if (|s.spec) begin
            // one shared vector; handler finds the source
            n.vec.valid = 1'b1;
            n.vec.nmi = 1'b1;
            n.vec.fixed = 1'b1;
            n.vec.addr = VEC_SPECIAL;
            n.spec = '0;
        end else if (s.ctrl[CTRL_I]) begin
            // highest level above the current threshold wins
            for (int k = 0; k < NSLOT; k++) begin
                if (s.pend[k] && lvl_of(s.lvl, k) > ipl && lvl_of(s.lvl, k) > best_lv) begin
                    best_lv = lvl_of(s.lvl, k);
                    best = k;
                end
            end
            if (best_lv != 3'h0) begin
                n.vec.valid = 1'b1;
                n.vec.num = SLOT_NUM[best];
                n.vec.addr = reloc(s.vbase, SLOT_NUM[best]);
                pend_clr[best] = 1'b1;
            end
        end
        // restore stacked select flag on return
        if (iret & iret_restore & ~n.vec.push_u) begin
            n.u = iret_u;
        end
        // monitor 1 routed by its choice bit
        if (s.ctrl[CTRL_VM1]) begin
            spec_new[2] = 1'b0;
        end else begin
            spec_new[2] = vmon1_evt;
        end
        // monitor 2 routed by its choice bit
        spec_new[3] = vmon2_evt & ~s.ctrl[CTRL_VM2];
        spec_new[1:0] = {osc_stop_evt, wdt_evt};
        // A new event in the clearing cycle is kept
        n.spec = n.spec | spec_new;
        // one request bit per source; no reserved slots exist
        n.pend = (s.pend & ~pend_clr) |
                 {vmon2_evt & s.ctrl[CTRL_VM2], vmon1_evt & s.ctrl[CTRL_VM1], periph_req};
        if (n.vec.valid) begin
            n.last_addr = n.vec.addr;
            n.last_num = n.vec.num;
            n.last_nmi = n.vec.nmi;
        end
        n.aw_rdy = ~n.aw_full & ~n.b_valid;
        n.w_rdy = ~n.w_full & ~n.b_valid;
        n.ar_rdy = ~n.r_valid;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign awready = s.aw_rdy;
    assign wready = s.w_rdy;
    assign bvalid = s.b_valid;
    assign bresp = s.b_resp;
    assign arready = s.ar_rdy;
    assign rvalid = s.r_valid;
    assign rdata = s.r_data;
    assign rresp = s.r_resp;
    // vector address handed to the CPU
    assign vec_o = s.vec;
    assign u_flag = s.u;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    sequence swi_low;
        trap_req.valid && trap_req.kind == TRAP_SWI && trap_req.num < SWI_KEEP_U;
    endsequence
    sequence swi_high;
        trap_req.valid && trap_req.kind == TRAP_SWI && trap_req.num >= SWI_KEEP_U;
    endsequence

    a_mask_gate_taken: assert property (
        vec_o.valid && !vec_o.nmi |-> $past(s.ctrl[CTRL_I]) && $past(s.ctrl[CTRL_IPL +: 3]) != 3'h7)
        else $error("maskable vector while mask flag clear");
    a_special_nmi_vec: assert property (
        !trap_req.valid && !m_hit && (|s.spec) |=> vec_o.valid && vec_o.nmi && vec_o.addr == VEC_SPECIAL)
        else $error("special source not dispatched to shared vector");
    a_illegal_vec: assert property (
        trap_req.valid && trap_req.kind == TRAP_UND |=> vec_o.valid && vec_o.addr == VEC_UND)
        else $error("illegal opcode vector wrong");
    a_ovf_wrap_gate: assert property (
        trap_req.valid && trap_req.kind == TRAP_OVF |=> vec_o.valid == $past(wrap_flag)
            && (!vec_o.valid || vec_o.addr == VEC_OVF))
        else $error("overflow trap gating wrong");
    a_brk_relocate: assert property (
        trap_req.valid && trap_req.kind == TRAP_BRK && brk_mark_byte == BRK_RELOC_MARK
            |=> vec_o.addr == $past(s.vbase) && !vec_o.fixed)
        else $error("breakpoint not relocated");
    a_swi_low_push: assert property (
        swi_low |=> vec_o.push_u && vec_o.u_saved == $past(s.u) && !u_flag)
        else $error("stack select not pushed and cleared");
    a_swi_high_keep: assert property (
        swi_high and !iret |=> u_flag == $past(s.u) && !vec_o.push_u)
        else $error("stack select changed for upper trap");
    a_iret_restore_u: assert property (
        iret && iret_restore && !trap_req.valid |=> u_flag == $past(iret_u))
        else $error("stack select not restored");
    a_match_vector: assert property (
        !trap_req.valid && m_hit |=> vec_o.valid && vec_o.nmi && vec_o.addr == VEC_MATCH)
        else $error("address match vector wrong");
    a_reloc_entry_addr: assert property (
        !trap_req.valid ##1 vec_o.valid && !vec_o.fixed
            |-> vec_o.addr == reloc($past(s.vbase), vec_o.num))
        else $error("relocatable entry address wrong");
    a_fixed_table_range: assert property (
        vec_o.valid && vec_o.fixed |-> vec_o.addr >= FIXED_LO && vec_o.addr < VEC_RSVD
            && vec_o.addr[1:0] == 2'h0)
        else $error("fixed vector outside table");
    a_vmon1_route: assert property (
        vmon1_evt && s.ctrl[CTRL_VM1] |=> s.pend[SLOT_VM1] && !s.spec[2])
        else $error("monitor 1 maskable route lost");
    a_vmon2_route: assert property (
        vmon2_evt && !s.ctrl[CTRL_VM2] |=> s.spec[3] || vec_o.addr == VEC_SPECIAL)
        else $error("monitor 2 non-maskable route lost");
    a_periph_set_wins: assert property (
        |periph_req |=> (s.pend[15:0] & $past(periph_req)) == $past(periph_req))
        else $error("peripheral request lost");
endmodule

// ---- rtl/isvm_pkg.sv ----
// Constants, field layout and carrier types of the interrupt source and vector map.
// Assumes one 40 MHz clock domain and a 20-bit CPU address space.
package isvm_pkg;
    localparam int unsigned ADDR_W = 20;
    localparam int unsigned NUM_W = 6;
    localparam int unsigned VEC_BYTES = 4;
    localparam int unsigned RELOC_BYTES = 256;
    localparam logic [ADDR_W-1:0] FIXED_LO = 20'h0ffdc;
    localparam logic [ADDR_W-1:0] FIXED_HI = 20'h0ffff;
    localparam logic [ADDR_W-1:0] VEC_UND = 20'h0ffdc;
    localparam logic [ADDR_W-1:0] VEC_OVF = 20'h0ffe0;
    localparam logic [ADDR_W-1:0] VEC_BRK = 20'h0ffe4;
    localparam logic [ADDR_W-1:0] VEC_MATCH = 20'h0ffe8;
    localparam logic [ADDR_W-1:0] VEC_STEP = 20'h0ffec;
    localparam logic [ADDR_W-1:0] VEC_SPECIAL = 20'h0fff0;
    localparam logic [ADDR_W-1:0] VEC_ABREAK = 20'h0fff4;
    localparam logic [ADDR_W-1:0] VEC_RSVD = 20'h0fff8;
    localparam logic [ADDR_W-1:0] VEC_RESET = 20'h0fffc;
    localparam logic [7:0] BRK_RELOC_MARK = 8'hff;
    localparam logic [NUM_W-1:0] NUM_BRK = 6'h00;
    localparam logic [NUM_W-1:0] SWI_KEEP_U = 6'h20;
    // Hardware sources: 16 peripherals, then both voltage monitors
    localparam int unsigned NSLOT = 18;
    localparam int unsigned SLOT_VM1 = 16;
    localparam int unsigned SLOT_VM2 = 17;
    localparam logic [NUM_W-1:0] SLOT_NUM [NSLOT] = '{
        6'h01, 6'h07, 6'h0b, 6'h0c, 6'h0d, 6'h0e, 6'h11, 6'h12, 6'h15,
        6'h16, 6'h18, 6'h19, 6'h1a, 6'h1d, 6'h1e, 6'h2a, 6'h32, 6'h33};
    localparam int unsigned LVL_STRIDE = 4;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_VBASE = 8'h08;
    localparam logic [7:0] REG_MATCH0 = 8'h0c;
    localparam logic [7:0] REG_MATCH1 = 8'h10;
    localparam logic [7:0] REG_LVL0 = 8'h14;
    localparam logic [7:0] REG_LVL1 = 8'h18;
    localparam logic [7:0] REG_LVL2 = 8'h1c;
    localparam logic [7:0] REG_PEND = 8'h20;
    // Control register fields
    localparam int unsigned CTRL_I = 0;
    localparam int unsigned CTRL_VM1 = 1;
    localparam int unsigned CTRL_VM2 = 2;
    localparam int unsigned CTRL_ME0 = 3;
    localparam int unsigned CTRL_ME1 = 4;
    localparam int unsigned CTRL_IPL = 8;
    localparam logic [31:0] CTRL_MASK = 32'h0000071f;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {TRAP_NONE, TRAP_UND, TRAP_OVF, TRAP_BRK, TRAP_SWI} trap_kind_t;
    typedef struct packed {
        logic valid;
        trap_kind_t kind;
        logic [NUM_W-1:0] num;
    } trap_req_t;
    typedef struct packed {
        logic valid;
        logic nmi;
        logic fixed;
        logic push_u;
        logic u_saved;
        logic [NUM_W-1:0] num;
        logic [ADDR_W-1:0] addr;
    } vec_t;
endpackage

// ---- verif/cpu_source_model.sv ----
// Far side: CPU trap decoder, fetch unit, return logic and request sources.
// Assumes the bench calls one task at a time; all changes land just after clk.
`timescale 1ns/1ps
module cpu_source_model
    import isvm_pkg::*;
(
    input wire logic clk,
    output trap_req_t trap_req,
    output logic wrap_flag,
    output logic [7:0] brk_mark_byte,
    output logic [ADDR_W-1:0] fetch_addr,
    output logic fetch_valid,
    output logic iret,
    output logic iret_restore,
    output logic iret_u,
    output logic [15:0] periph_req,
    output logic [3:0] spec_evt
);
    initial begin
        trap_req = '0;
        wrap_flag = 1'b0;
        brk_mark_byte = 8'h00;
        fetch_addr = '0;
        fetch_valid = 1'b0;
        iret = 1'b0;
        iret_restore = 1'b0;
        iret_u = 1'b0;
        periph_req = 16'h0000;
        spec_evt = 4'h0;
    end
    // no debug-only vectors: only trap kinds exist here
    task automatic trap(input trap_kind_t k, input logic [5:0] n, input logic w, input logic [7:0] m);
        @(posedge clk);
        trap_req <= '{valid: 1'b1, kind: k, num: n};
        wrap_flag <= w;
        brk_mark_byte <= m;
        @(posedge clk);
        trap_req <= '0;
        wrap_flag <= ~w;
        brk_mark_byte <= ~m;
    endtask
    task automatic fetch(input logic [ADDR_W-1:0] a);
        @(posedge clk);
        fetch_addr <= a;
        fetch_valid <= 1'b1;
        @(posedge clk);
        fetch_valid <= 1'b0;
        fetch_addr <= ~a;
    endtask
    task automatic ret(input logic r, input logic u);
        @(posedge clk);
        iret <= 1'b1;
        iret_restore <= r;
        iret_u <= u;
        @(posedge clk);
        iret <= 1'b0;
        iret_restore <= 1'b0;
    endtask
    // Bits: watchdog, oscillation stop, monitor 1, monitor 2
    task automatic pulse(input logic sp, input int k);
        @(posedge clk);
        if (sp) spec_evt <= 4'h1 << k;
        else periph_req <= 16'h0001 << k;
        @(posedge clk);
        spec_evt <= 4'h0;
        periph_req <= 16'h0000;
    endtask
endmodule

// ---- verif/interrupt_source_vector_map_test.sv ----
// Self-checking bench: AXI4-Lite master, vector queue and monitor.
// Assumes the design package and the far-side model are compiled first.
`timescale 1ns/1ps
module interrupt_source_vector_map_test
    import isvm_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, u_flag, wrap_flag, fetch_valid, iret, iret_restore, iret_u;
    logic [1:0] bresp, rresp;
    logic [7:0] brk_mark_byte;
    logic [ADDR_W-1:0] fetch_addr, vbase;
    logic [15:0] periph_req;
    logic [3:0] spec_evt;
    trap_req_t trap_req;
    vec_t vec_o, e;
    vec_t exp_q[$];
    int fails = 0, n_compared = 0;
    logic [5:0] nlist[8] = '{6'd0, 6'd5, 6'd31, 6'd32, 6'd41, 6'd56, 6'd63, 6'd9};
    always #12.5 clk = ~clk;
    interrupt_source_vector_map dut (.clk(clk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .trap_req(trap_req),
        .wrap_flag(wrap_flag), .brk_mark_byte(brk_mark_byte), .fetch_addr(fetch_addr),
        .fetch_valid(fetch_valid), .iret(iret), .iret_restore(iret_restore), .iret_u(iret_u),
        .periph_req(periph_req), .wdt_evt(spec_evt[0]), .osc_stop_evt(spec_evt[1]),
        .vmon1_evt(spec_evt[2]), .vmon2_evt(spec_evt[3]), .vec_o(vec_o), .u_flag(u_flag));
    cpu_source_model m (.clk(clk), .trap_req(trap_req), .wrap_flag(wrap_flag), .brk_mark_byte(brk_mark_byte),
        .fetch_addr(fetch_addr), .fetch_valid(fetch_valid), .iret(iret), .iret_restore(iret_restore),
        .iret_u(iret_u), .periph_req(periph_req), .spec_evt(spec_evt));
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
        n_compared++;
        if (g !== ex) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, ex, g);
        end
    endtask
    // Handshakes judged at the falling edge, acted on at the next rising edge
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        logic [1:0] r;
        int t;
        t = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            r = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            t++;
        end while (tb !== 1'b1 && t < 40);
        bready <= 1'b0;
        if (tb !== 1'b1) chk("bvalid", 1, 0);
        chk("bresp", er, r);
    endtask
    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic ta, tr;
        int t;
        t = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk);
            ta = arvalid & arready;
            tr = rvalid;
            if (tr === 1'b1) begin
                chk("rresp", er, rresp);
                chk("rdata", ed, rdata);
            end
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
            t++;
        end while (tr !== 1'b1 && t < 40);
        rready <= 1'b0;
        if (tr !== 1'b1) chk("rvalid", 1, 0);
    endtask
    task automatic expv(input logic [ADDR_W-1:0] a, input logic n, input logic f, input logic p);
        e = '0;
        e.addr = a;
        e.nmi = n;
        e.fixed = f;
        e.push_u = p;
        // Every low trap follows a return that sets u
        e.u_saved = p;
        exp_q.push_back(e);
    endtask
    // Fixed tail also proves no late or extra vector
    task automatic settle();
        int t;
        t = 0;
        while (exp_q.size() != 0 && t < 30) begin
            @(posedge clk);
            t++;
        end
        repeat (4) @(posedge clk);
        chk("vectors left", 0, 32'(exp_q.size()));
    endtask
    always @(negedge clk) begin
        if (vec_o.valid === 1'b1) begin
            if (exp_q.size() == 0) chk("unexpected vector", 0, {11'h0, 1'b1, vec_o.addr});
            else begin
                e = exp_q.pop_front();
                chk("vec addr", e.addr, vec_o.addr);
                chk("vec kind", {e.nmi, e.fixed, e.push_u, e.u_saved}, {vec_o.nmi, vec_o.fixed, vec_o.push_u, vec_o.u_saved});
                if (!e.fixed) chk("vec num", 32'((e.addr - vbase) >> 2), vec_o.num);
            end
        end
    end
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        print_verdict();
    end
    initial begin
        void'($urandom(32'h3891));
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        vbase = 20'($urandom) & 20'h7fffc;
        nlist[7] = 6'($urandom);
        chk("u_flag reset", 0, u_flag);
        axr(REG_CTRL, 0, RESP_OKAY);
        axw(REG_CTRL, 32'hffffffff, RESP_OKAY);
        axr(REG_CTRL, CTRL_MASK, RESP_OKAY);
        wstrb <= 4'h2;
        axw(REG_CTRL, 0, RESP_OKAY);
        axr(REG_CTRL, CTRL_MASK & 32'h000000ff, RESP_OKAY);
        wstrb <= 4'hf;
        axw(REG_CTRL, 0, RESP_OKAY);
        axw(REG_VBASE, {12'h0, vbase}, RESP_OKAY);
        axw(REG_STAT, 32'h0, RESP_OKAY);
        axw(8'h40, 32'h0, RESP_SLVERR);
        axr(8'h40, 0, RESP_SLVERR);
        expv(VEC_UND, 1, 1, 0);
        m.trap(TRAP_UND, 6'd0, 1'b0, 8'h00);
        m.trap(TRAP_OVF, 6'd0, 1'b0, 8'h00);
        expv(VEC_OVF, 1, 1, 0);
        m.trap(TRAP_OVF, 6'd0, 1'b1, 8'h00);
        expv(VEC_BRK, 1, 1, 0);
        m.trap(TRAP_BRK, 6'd0, 1'b0, 8'h00);
        expv(vbase, 1, 0, 0);
        m.trap(TRAP_BRK, 6'd0, 1'b0, BRK_RELOC_MARK);
        settle();
        for (int i = 0; i < 8; i++) begin
            m.ret(1'b1, 1'b1);
            settle();
            chk("u_flag restore", 1, u_flag);
            expv(vbase + 20'(4 * nlist[i]), 1, 0, nlist[i] < 32);
            m.trap(TRAP_SWI, nlist[i], 1'b0, 8'h00);
            settle();
            chk("u_flag after trap", nlist[i] >= 32, u_flag);
        end
        for (int k = 0; k < 4; k++) begin
            expv(VEC_SPECIAL, 1, 1, 0);
            m.pulse(1'b1, k);
            settle();
        end
        axw(REG_MATCH0, 32'h01234, RESP_OKAY);
        axw(REG_MATCH1, 32'h0abc8, RESP_OKAY);
        m.fetch(20'h01234);
        axw(REG_CTRL, 32'h8, RESP_OKAY);
        expv(VEC_MATCH, 1, 1, 0);
        m.fetch(20'h01234);
        m.fetch(20'h0abc8);
        settle();
        axw(REG_CTRL, 32'h10, RESP_OKAY);
        expv(VEC_MATCH, 1, 1, 0);
        m.fetch(20'h0abc8);
        settle();
        axw(REG_LVL0, 32'h11111111, RESP_OKAY);
        axw(REG_LVL1, 32'h11111111, RESP_OKAY);
        axw(REG_LVL2, 32'h11, RESP_OKAY);
        axw(REG_CTRL, 32'h7, RESP_OKAY);
        for (int k = 0; k < 16; k++) begin
            expv(vbase + 20'(4 * SLOT_NUM[k]), 0, 0, 0);
            m.pulse(1'b0, k);
            settle();
        end
        expv(vbase + 20'd200, 0, 0, 0);
        m.pulse(1'b1, 2);
        expv(vbase + 20'd204, 0, 0, 0);
        m.pulse(1'b1, 3);
        settle();
        axw(REG_LVL0, 32'h30, RESP_OKAY);
        axw(REG_CTRL, 32'h0, RESP_OKAY);
        m.pulse(1'b0, 1);
        settle();
        axw(REG_CTRL, 32'h301, RESP_OKAY);
        settle();
        expv(vbase + 20'd28, 0, 0, 0);
        axw(REG_CTRL, 32'h201, RESP_OKAY);
        settle();
        m.pulse(1'b0, 0);
        settle();
        print_verdict();
    end
endmodule
